//--- logic/sbst_pkg.sv
/*
 * Constants, state and instruction types for the SRAM boundary-scan test port.
 * Assumes a single core clock at 10 MHz; the test clock is sampled as data.
 */
package sbst_pkg;
   localparam int IR_WIDTH = 3;
   localparam int BSR_LENGTH = 107;
   localparam int IDR_WIDTH = 32;
   localparam int BSR_OUT_ENABLE_BIT = 47;
   localparam int IDR_VERSION_LSB = 29;
   localparam int IDR_PART_LSB = 12;
   localparam int IDR_MAKER_LSB = 1;
   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_IDCODE = 3'h1;
   localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
   localparam logic [2:0] IR_SAMPLE_PRELOAD = 3'h4;
   localparam logic [2:0] IR_BYPASS = 3'h7;
   localparam logic [2:0] IR_CAPTURE_PATTERN = 3'h1;
   localparam int RESET_TMS_EDGES = 5;
   localparam int SYNC_STAGES = 3;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAUSE_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR
   } sbst_state_type;
endpackage : sbst_pkg

//--- logic/sbst_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one pin input.
 * Assumes the input is asynchronous to core_clk; output changes once stages two and three agree.
 */
module sbst_sync (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   logic [2:0] stage_q;
   logic [2:0] stage_d;
   logic level_q;
   logic level_d;

   always_comb begin
      stage_d = {stage_q[1:0], pin};
      level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stage_q <= 3'h0;
         level_q <= 1'b0;
      end else begin
         stage_q <= stage_d;
         level_q <= level_d;
      end
   end

   assign level = level_q;
endmodule : sbst_sync

//--- logic/sbst_tap.sv
/*
 * Boundary-scan test access port: controller, instruction register, bypass,
 * identification and 107-cell boundary register.
 * Assumes the test clock, mode select and serial input arrive from pins; the
 * boundary ring is presented as a parallel vector from the memory core.
 */
// Summary of operation
// - Boundary register of 107 cells, one-cell bypass and 32-bit identification register.
// - Identification bits 31:29 hold version, bits 28:12 hold part type, hardwired.
// - Identification bits 11:1 hold the eleven-bit manufacturer code.
// - Identification bit 0 always reads one.
// - Code 000 captures the boundary ring into the boundary register.
// - Code 001 loads the identification register onto the serial path.
// - Code 010 captures pins, selects boundary register, forces memory outputs high impedance.
// - Code 100 captures the ring and selects boundary register, memory unaffected.
// - Code 111 selects the bypass cell, memory unaffected.
// - Serial input sampled on rising test clock, output changed on falling edge.
// - Capture-instruction state loads 01 into the two low instruction shift bits.
// - Power up and test-logic-reset make the instruction register hold identification read.
// - Mode select high for five rising edges resets the port.
module sbst_tap #(
   parameter logic [2:0] VERSION = 3'h0,           // Arbitrary value
   parameter logic [16:0] PART_TYPE = 17'h00a5a,   // Arbitrary value
   parameter logic [10:0] MAKER_CODE = 11'h155     // Arbitrary value
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic test_clk,
   input wire logic test_mode_sel,
   input wire logic test_data_in,
   input wire logic [sbst_pkg::BSR_LENGTH-1:0] ring_in,
   output logic test_data_out,
   output logic test_data_out_en,
   output logic [sbst_pkg::BSR_LENGTH-1:0] bsr_update,
   output logic extest_active,
   output logic mem_out_enable
);
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic tck_q;
   logic rise;
   logic fall;
   logic bsr_sel;
   sbst_pkg::sbst_state_type st_q, st_d;
   logic [2:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
   logic byp_q, byp_d;
   logic [31:0] id_q, id_d;
   logic [sbst_pkg::BSR_LENGTH-1:0] bsr_q, bsr_d, upd_q, upd_d;
   logic tdo_q, tdo_d, tdo_en_q, tdo_en_d;
   logic [31:0] id_word;
   logic [2:0] hi_cnt_q, hi_cnt_d;

   sbst_sync u_sync_tck (.core_clk(core_clk), .rst(rst), .pin(test_clk), .level(tck_s));
   sbst_sync u_sync_tms (.core_clk(core_clk), .rst(rst), .pin(test_mode_sel), .level(tms_s));
   sbst_sync u_sync_tdi (.core_clk(core_clk), .rst(rst), .pin(test_data_in), .level(tdi_s));

   assign rise = tck_s & ~tck_q;
   assign fall = ~tck_s & tck_q;
   assign id_word = {VERSION, PART_TYPE, MAKER_CODE, 1'b1};
   // Reserved codes fall back to the bypass cell so an unused code never disturbs the boundary register
   assign bsr_sel = (ir_q == sbst_pkg::IR_EXTEST) || (ir_q == sbst_pkg::IR_SAMPLE_Z) ||
                    (ir_q == sbst_pkg::IR_SAMPLE_PRELOAD);

   always_comb begin
      st_d = st_q;
      if (rise) begin
         case (st_q)
            sbst_pkg::ST_RESET: st_d = tms_s ? sbst_pkg::ST_RESET : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_IDLE: st_d = tms_s ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_DR: st_d = tms_s ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
            sbst_pkg::ST_CAP_DR: st_d = tms_s ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_SH_DR: st_d = tms_s ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_EX1_DR: st_d = tms_s ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_PAUSE_DR;
            sbst_pkg::ST_PAUSE_DR: st_d = tms_s ? sbst_pkg::ST_EX2_DR : sbst_pkg::ST_PAUSE_DR;
            sbst_pkg::ST_EX2_DR: st_d = tms_s ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_UPD_DR: st_d = tms_s ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_IR: st_d = tms_s ? sbst_pkg::ST_RESET : sbst_pkg::ST_CAP_IR;
            sbst_pkg::ST_CAP_IR: st_d = tms_s ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_SH_IR: st_d = tms_s ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_EX1_IR: st_d = tms_s ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_PAUSE_IR;
            sbst_pkg::ST_PAUSE_IR: st_d = tms_s ? sbst_pkg::ST_EX2_IR : sbst_pkg::ST_PAUSE_IR;
            sbst_pkg::ST_EX2_IR: st_d = tms_s ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_UPD_IR: st_d = tms_s ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            default: st_d = sbst_pkg::ST_RESET;
         endcase
      end
      // Five high mode-select edges win over the table from any state
      if (rise && hi_cnt_d == 3'(sbst_pkg::RESET_TMS_EDGES)) begin
         st_d = sbst_pkg::ST_RESET;
      end
   end

   // Counts consecutive high mode-select edges; five of them force reset from any state
   always_comb begin
      hi_cnt_d = hi_cnt_q;
      if (rise) begin
         if (!tms_s) begin
            hi_cnt_d = 3'h0;
         end else if (hi_cnt_q != 3'(sbst_pkg::RESET_TMS_EDGES)) begin
            hi_cnt_d = hi_cnt_q + 3'h1;
         end
      end
   end

   always_comb begin
      ir_sh_d = ir_sh_q;
      ir_d = ir_q;
      byp_d = byp_q;
      id_d = id_q;
      bsr_d = bsr_q;
      upd_d = upd_q;
      if (st_q == sbst_pkg::ST_RESET) begin
         ir_d = sbst_pkg::IR_IDCODE;
         upd_d[sbst_pkg::BSR_OUT_ENABLE_BIT] = 1'b1;
      end
      if (rise) begin
         case (st_q)
            sbst_pkg::ST_CAP_IR: ir_sh_d = sbst_pkg::IR_CAPTURE_PATTERN;
            sbst_pkg::ST_SH_IR: ir_sh_d = {tdi_s, ir_sh_q[2:1]};
            sbst_pkg::ST_UPD_IR: ir_d = ir_sh_q;
            sbst_pkg::ST_CAP_DR: begin
               byp_d = 1'b0;
               if (ir_q == sbst_pkg::IR_IDCODE) begin
                  id_d = id_word;
               end else if (ir_q == sbst_pkg::IR_EXTEST || ir_q == sbst_pkg::IR_SAMPLE_Z ||
                            ir_q == sbst_pkg::IR_SAMPLE_PRELOAD) begin
                  bsr_d = ring_in;
               end
            end
            sbst_pkg::ST_SH_DR: begin
               if (ir_q == sbst_pkg::IR_IDCODE) begin
                  id_d = {tdi_s, id_q[31:1]};
               end else if (bsr_sel) begin
                  bsr_d = {tdi_s, bsr_q[sbst_pkg::BSR_LENGTH-1:1]};
               end else begin
                  byp_d = tdi_s;
               end
            end
            sbst_pkg::ST_UPD_DR: begin
               if (ir_q == sbst_pkg::IR_EXTEST || ir_q == sbst_pkg::IR_SAMPLE_PRELOAD) begin
                  upd_d = bsr_q;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Serial output moves only on the falling test clock edge
   always_comb begin
      tdo_d = tdo_q;
      tdo_en_d = tdo_en_q;
      if (fall) begin
         tdo_en_d = (st_q == sbst_pkg::ST_SH_DR) || (st_q == sbst_pkg::ST_SH_IR);
         if (st_q == sbst_pkg::ST_SH_IR) begin
            tdo_d = ir_sh_q[0];
         end else if (ir_q == sbst_pkg::IR_IDCODE) begin
            tdo_d = id_q[0];
         end else if (bsr_sel) begin
            tdo_d = bsr_q[0];
         end else begin
            tdo_d = byp_q;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tck_q <= 1'b0;
         st_q <= sbst_pkg::ST_RESET;
         hi_cnt_q <= 3'h0;
         ir_sh_q <= sbst_pkg::IR_IDCODE;
         ir_q <= sbst_pkg::IR_IDCODE;
         byp_q <= 1'b0;
         id_q <= 32'h0;
         bsr_q <= '0;
         upd_q <= '0;
         tdo_q <= 1'b0;
         tdo_en_q <= 1'b0;
      end else begin
         tck_q <= tck_s;
         st_q <= st_d;
         hi_cnt_q <= hi_cnt_d;
         ir_sh_q <= ir_sh_d;
         ir_q <= ir_d;
         byp_q <= byp_d;
         id_q <= id_d;
         bsr_q <= bsr_d;
         upd_q <= upd_d;
         tdo_q <= tdo_d;
         tdo_en_q <= tdo_en_d;
      end
   end

   assign test_data_out = tdo_q;
   assign test_data_out_en = tdo_en_q;
   assign bsr_update = upd_q;
   assign extest_active = (ir_q == sbst_pkg::IR_EXTEST);
   // Reserved codes are treated as bypass and leave memory outputs alone
   assign mem_out_enable = (ir_q == sbst_pkg::IR_SAMPLE_Z) ? 1'b0 :
                           (ir_q == sbst_pkg::IR_EXTEST) ? upd_q[sbst_pkg::BSR_OUT_ENABLE_BIT] : 1'b1;

   AST_RESET_IR: assert property (@(posedge core_clk) disable iff (rst)
      st_q == sbst_pkg::ST_RESET |=> ir_q == sbst_pkg::IR_IDCODE) else $error("ir not idcode after reset");
   AST_CAP_IR: assert property (@(posedge core_clk) disable iff (rst)
      rise && st_q == sbst_pkg::ST_CAP_IR |=> ir_sh_q == 3'h1) else $error("capture ir pattern wrong");
   AST_ID_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
      rise && st_q == sbst_pkg::ST_CAP_DR && ir_q == sbst_pkg::IR_IDCODE |=> id_q[0] == 1'b1 && id_q[11:1] == MAKER_CODE)
      else $error("id capture wrong");
   AST_ID_FIELDS: assert property (@(posedge core_clk) disable iff (rst)
      rise && st_q == sbst_pkg::ST_CAP_DR && ir_q == sbst_pkg::IR_IDCODE |=> id_q[31:12] == {VERSION, PART_TYPE})
      else $error("id upper fields wrong");
   AST_MAKER: assert property (@(posedge core_clk) disable iff (rst)
      rise && st_q == sbst_pkg::ST_CAP_DR && ir_q == sbst_pkg::IR_IDCODE |=> id_q[11:1] == MAKER_CODE)
      else $error("maker code wrong");
   AST_BSR_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
      rise && st_q == sbst_pkg::ST_CAP_DR && ir_q == sbst_pkg::IR_SAMPLE_PRELOAD |=> bsr_q == $past(ring_in))
      else $error("boundary capture wrong");
   AST_EXTEST_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
      rise && st_q == sbst_pkg::ST_CAP_DR && ir_q == sbst_pkg::IR_EXTEST |=> bsr_q == $past(ring_in))
      else $error("extest capture wrong");
   AST_HIZ: assert property (@(posedge core_clk) disable iff (rst)
      ir_q == sbst_pkg::IR_SAMPLE_Z |-> !mem_out_enable) else $error("outputs not high z");
   AST_IDCODE_NO_EFFECT: assert property (@(posedge core_clk) disable iff (rst)
      ir_q == sbst_pkg::IR_IDCODE || ir_q == sbst_pkg::IR_BYPASS |-> mem_out_enable) else $error("memory disturbed");
   AST_BYPASS_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
      rise && st_q == sbst_pkg::ST_CAP_DR && ir_q == sbst_pkg::IR_BYPASS |=> !byp_q) else $error("bypass not zero");
   AST_TDO_FALL: assert property (@(posedge core_clk) disable iff (rst)
      !fall |=> $stable(test_data_out)) else $error("tdo moved off falling edge");
   AST_FIVE_HIGH: assert property (@(posedge core_clk) disable iff (rst)
      rise && hi_cnt_q == 3'h4 && tms_s |=> st_q == sbst_pkg::ST_RESET) else $error("no reset after five");
   AST_FSM_IDLE: assert property (@(posedge core_clk) disable iff (rst)
      rise && st_q == sbst_pkg::ST_RESET && !tms_s |=> st_q == sbst_pkg::ST_IDLE) else $error("fsm step wrong");
   AST_BSR_LEN: assert property (@(posedge core_clk) disable iff (rst)
      rise && st_q == sbst_pkg::ST_SH_DR && ir_q == sbst_pkg::IR_SAMPLE_PRELOAD |=> bsr_q[106] == $past(tdi_s))
      else $error("bsr shift wrong");
endmodule : sbst_tap

//--- tb/sbst_ctl_model.sv
/*
 * Behavioural boundary-scan test controller that walks the port's state machine.
 * Assumes it is called from the bench at a falling core clock edge; test clock rests low between calls.
 */
module sbst_ctl_model (
   input wire logic core_clk,
   output logic test_clk,
   output logic test_mode_sel,
   output logic test_data_in,
   input wire logic test_data_out,
   input wire logic test_data_out_en
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      test_clk = 1'b0;
      test_mode_sel = 1'b1;
      test_data_in = 1'b0;
   end

   // One 800 ns test clock period; serial out is read in the high phase, before the device may change it
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      test_mode_sel = tms;
      test_data_in = tdi;
      repeat (4) @(negedge core_clk);
      test_clk = 1'b1;
      repeat (2) @(negedge core_clk);
      // An undriven serial output shows the inverse of its last level, so a missing enable is caught
      tdo = test_data_out_en ? test_data_out : ~test_data_out;
      repeat (2) @(negedge core_clk);
      test_clk = 1'b0;
   endtask : step

   // Ends in Run-Test/Idle
   task automatic reset5();
      logic b;
      repeat (5) step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
   endtask : reset5

   // From Idle: capture, shift n bits LSB first, update, back to Idle
   task automatic scan(input logic ir, input int n, input logic [sbst_pkg::BSR_LENGTH-1:0] din,
                       output logic [sbst_pkg::BSR_LENGTH-1:0] dout);
      logic b;
      dout = '0;
      step(1'b1, 1'b0, b);
      if (ir) step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
      step(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
      // The port acts on each test clock edge about five core cycles late; let the last update land
      repeat (8) @(negedge core_clk);
   endtask : scan
endmodule : sbst_ctl_model

//--- tb/sbst_tap_test.sv
/*
 * Self-checking bench for the boundary-scan port: identification, bypass, preload, external test, sample-Z, reset.
 * Assumes the controller model drives the test pins; the bench drives the boundary ring and reset.
 */
module sbst_tap_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int N = sbst_pkg::BSR_LENGTH;
   localparam logic [2:0] VER = 3'h5; // Arbitrary value
   localparam logic [16:0] PART = 17'h1c3e7; // Arbitrary value
   localparam logic [10:0] MAKER = 11'h2b6; // Arbitrary value
   localparam logic [N-1:0] RING = 107'h5_dead_beef_0123_4567_89ab_cd81;
   logic core_clk, rst, test_clk, test_mode_sel, test_data_in, test_data_out, test_data_out_en;
   logic extest_active, mem_out_enable;
   logic [N-1:0] ring_in, bsr_update, dout, pre;
   int n_mismatch, n_tests;

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   sbst_tap #(.VERSION(VER), .PART_TYPE(PART), .MAKER_CODE(MAKER)) dut (.core_clk(core_clk), .rst(rst),
      .test_clk(test_clk), .test_mode_sel(test_mode_sel), .test_data_in(test_data_in), .ring_in(ring_in),
      .test_data_out(test_data_out), .test_data_out_en(test_data_out_en), .bsr_update(bsr_update),
      .extest_active(extest_active), .mem_out_enable(mem_out_enable));
   sbst_ctl_model model (.core_clk(core_clk), .test_clk(test_clk), .test_mode_sel(test_mode_sel),
      .test_data_in(test_data_in), .test_data_out(test_data_out), .test_data_out_en(test_data_out_en));

   task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   // Only four of the five defined codes are ever loaded; identification comes from reset
   task automatic load_ir(input logic [2:0] code);
      model.scan(1'b1, 3, N'(code), dout);
      chk(N'(dout[1:0]), N'(2'h1));
   endtask : load_ir

   task automatic t_idcode();
      model.scan(1'b0, 32, '0, dout);
      chk(N'(dout[31:0]), N'({VER, PART, MAKER, 1'b1}));
      chk(N'(test_data_out_en), N'(1'b0));
   endtask : t_idcode

   // Bypass cell is cleared at capture, so a zero leads the delayed stream
   task automatic t_bypass();
      load_ir(sbst_pkg::IR_BYPASS);
      model.scan(1'b0, 4, N'(4'hb), dout);
      chk(N'(dout[3:0]), N'(4'h6));
      chk(N'(mem_out_enable), N'(1'b1));
   endtask : t_bypass

   // Preload clears the output-bus cell so the next external test shows it on the enable
   task automatic t_preload();
      pre = ~RING;
      pre[sbst_pkg::BSR_OUT_ENABLE_BIT] = 1'b0;
      load_ir(sbst_pkg::IR_SAMPLE_PRELOAD);
      model.scan(1'b0, N, pre, dout);
      chk(dout, RING);
      chk(bsr_update, pre);
      chk(N'(mem_out_enable), N'(1'b1));
   endtask : t_preload

   // The enable cell preloaded low floats the outputs; a one shifted in and updated drives them again
   task automatic t_extest();
      pre = RING;
      pre[sbst_pkg::BSR_OUT_ENABLE_BIT] = 1'b1;
      load_ir(sbst_pkg::IR_EXTEST);
      chk(N'(extest_active), N'(1'b1));
      chk(N'(mem_out_enable), N'(1'b0));
      ring_in = ~RING;
      model.scan(1'b0, N, pre, dout);
      chk(dout, ~RING);
      chk(bsr_update, pre);
      chk(N'(mem_out_enable), N'(1'b1));
   endtask : t_extest

   task automatic t_samplez();
      load_ir(sbst_pkg::IR_SAMPLE_Z);
      chk(N'(mem_out_enable), N'(1'b0));
      chk(N'(extest_active), N'(1'b0));
      model.scan(1'b0, N, '0, dout);
      chk(dout, ~RING);
   endtask : t_samplez

   // Abort in mid Shift-DR; five high mode-select edges must bring identification back
   task automatic t_reset();
      logic b;
      model.step(1'b1, 1'b0, b);
      model.step(1'b0, 1'b0, b);
      model.step(1'b0, 1'b1, b);
      model.reset5();
      chk(N'(mem_out_enable), N'(1'b1));
      t_idcode();
   endtask : t_reset

   initial begin
      n_mismatch = 0;
      n_tests = 0;
      rst = 1'b1;
      ring_in = RING;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      model.reset5();
      t_idcode();
      t_bypass();
      t_preload();
      t_extest();
      t_samplez();
      t_reset();
      test_done();
   end

   // A hang costs a mismatch and still reaches the verdict
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      test_done();
   end
endmodule : sbst_tap_test
